// >>> core/sadc_cfg.svh
// constants of the serial converter control block
// assumes inclusion by the package and the design files
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH

`define SADC_RES_W       8
`define SADC_ADDR_W      4
`define SADC_CNT_W       3
`define SADC_CH_W        3
`define SADC_FIFO_DEPTH  8
`define SADC_FIFO_CNT_W  4
`define SADC_NBITS_1CH   3'h0
`define SADC_NBITS_2CH   3'h2
`define SADC_NBITS_4CH   3'h3
`define SADC_NBITS_8CH   3'h4
`define SADC_CNT_LAST    3'h1
`define SADC_TRIAL_INIT  8'h80
`define SADC_RESULT_RST  8'h00
`define SADC_ADDR_RST    4'h0
`define SADC_MSB_IDX     3'h7
`define SADC_LSB_IDX     3'h0
`define SADC_FIXED_POS   3'h0
`define SADC_FIXED_NEG   3'h1
`define SADC_FORCED_SEL0 1'h1
`define SADC_FORCED_SEL1 1'h0

`endif

// >>> core/sadc_pkg.sv
// types of the serial converter control block
// assumes sadc_cfg.svh on the include path
`include "sadc_cfg.svh"

package sadc_pkg;

  typedef enum logic [1:0] {
    SADC_VAR_1CH = 2'b00,
    SADC_VAR_2CH = 2'b01,
    SADC_VAR_4CH = 2'b10,
    SADC_VAR_8CH = 2'b11
  } sadc_variant_t;

  typedef enum logic [2:0] {
    SADC_ST_IDLE    = 3'b000,
    SADC_ST_WAIT    = 3'b001,
    SADC_ST_ADDR    = 3'b010,
    SADC_ST_SAMPLE  = 3'b011,
    SADC_ST_CONVERT = 3'b100,
    SADC_ST_SETTLE  = 3'b101,
    SADC_ST_REPLAY  = 3'b110,
    SADC_ST_DONE    = 3'b111
  } sadc_state_t;

  typedef struct packed {
    logic [`SADC_CH_W-1:0] pos_ch;
    logic [`SADC_CH_W-1:0] neg_ch;
    logic                  neg_common;
    logic                  common_grounded;
    logic                  single_ended;
  } sadc_mux_sel_t;

  typedef struct packed {
    sadc_mux_sel_t         sel;
    logic [`SADC_RES_W-1:0] result;
  } sadc_result_t;

endpackage : sadc_pkg

// >>> core/sadc_mux_decode.sv
// input multiplexer decode of the selection word
// assumes a padded word {single, odd, sel1, sel0}
`timescale 1ns/10ps
`include "sadc_cfg.svh"

module sadc_mux_decode import sadc_pkg::*; (
  input  wire sadc_variant_t          variant_in,
  input  wire logic [`SADC_ADDR_W-1:0] addr_in,
  output sadc_mux_sel_t               sel_out
);

  logic [1:0] pair;

  // ---------------------------------------------
  // pair select per variant
  // ---------------------------------------------
  always_comb begin
    case (variant_in)
      SADC_VAR_8CH: pair = addr_in[1:0];
      SADC_VAR_4CH: pair = {1'b0, addr_in[1]};
      default:      pair = 2'b00;
    endcase
  end

  // ---------------------------------------------
  // channel routing
  // ---------------------------------------------
  always_comb begin
    sel_out.single_ended    = addr_in[3];
    sel_out.pos_ch          = {pair, addr_in[2]};
    sel_out.neg_ch          = {pair, ~addr_in[2]};
    sel_out.neg_common      = addr_in[3];
    sel_out.common_grounded = (variant_in != SADC_VAR_8CH);
    if (variant_in == SADC_VAR_1CH) begin
      sel_out.single_ended = 1'b0;
      sel_out.pos_ch       = `SADC_FIXED_POS;
      sel_out.neg_ch       = `SADC_FIXED_NEG;
      sel_out.neg_common   = 1'b0;
    end
  end

endmodule : sadc_mux_decode

// >>> core/sadc_fifo.sv
// result buffer, head entry always at index zero
// assumes one clock and an active-low async reset
`timescale 1ns/10ps

module sadc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int CNT_W = 4
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic [CNT_W-1:0] wr_idx;
  logic             push;
  logic             pop;

  assign push         = in_valid_in & in_ready_out;
  assign pop          = out_valid_out & out_ready_in;
  assign wr_idx       = pop ? count_r - CNT_W'(1) : count_r;
  assign out_data_out = mem_r[0];

  always_comb begin
    count_nxt = count_r + CNT_W'(push) - CNT_W'(pop);
  end

  // ---------------------------------------------
  // level and flags
  // ---------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_r       <= '0;
      out_valid_out <= 1'b0;
      in_ready_out  <= 1'b1;
    end else begin
      count_r       <= count_nxt;
      out_valid_out <= (count_nxt != '0);
      in_ready_out  <= (count_nxt != CNT_W'(DEPTH));
    end
  end

  // ---------------------------------------------
  // storage, shifts toward the head on pop
  // ---------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < DEPTH; i++) mem_r[i] <= '0;
    end else begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        if (pop) mem_r[i] <= mem_r[i+1];
      end
      for (int i = 0; i < DEPTH; i++) begin
        if (push && (CNT_W'(i) == wr_idx)) mem_r[i] <= in_data_in;
      end
    end
  end

endmodule : sadc_fifo

// >>> core/sadc_top.sv
// control of a serial 8-bit successive-approximation converter
// assumes serial clock and pins synchronous to clk_sys_in,
// an analog core giving the comparator decision per trial code
`timescale 1ns/10ps
`include "sadc_cfg.svh"

// Summary of operation
// - reversed inputs give an all-zero result
// - differential pairs only adjacent channels
// - eight-channel single: channel 2*pair+odd
// - differential: odd bit swaps pair polarity
// - four-channel decode, common tied to ground
// - two-channel decode from single and odd
// - single-channel: fixed input, no selection word
// - eight-channel single uses common as negative
// - chip select low holds whole conversion
// - data in sampled on serial clock rise
// - first one on data in is start unless the result buffer is full
// - two to four selection bits follow start
// - half clock sample, then ignore data in
// - output drives leading zero one period
// - decisions out on falling edges, msb first
// - eight periods, status drops half later
// - replay disabled: result sent once only
// - replay armed early: lsb first right after
// - replay armed late: lsb first on falls
// - variants force replay enable on or off
// - chip select high clears everything except the result buffer
// - data in read only for start and selection
// - missing select bits forced in reduced variants
// - chip select high floats output and status
module sadc_top import sadc_pkg::*; (
  input  wire logic                  clk_sys_in,
  input  wire logic                  reset_n_in,
  input  wire logic                  cs_n_in,
  input  wire logic                  sclk_in,
  input  wire logic                  serial_data_in,
  input  wire logic                  lsb_replay_enable_n_in,
  input  wire sadc_variant_t         mux_variant_in,
  input  wire logic                  comparator_in,
  input  wire logic                  input_reversed_in,
  input  wire logic                  result_ready_in,
  output logic                       serial_data_out,
  output logic                       serial_data_oe_n_out,
  output logic                       conversion_active_out,
  output logic                       conversion_active_oe_n_out,
  output logic                       sample_out,
  output logic [`SADC_RES_W-1:0]     dac_code_out,
  output sadc_mux_sel_t              mux_select_out,
  output sadc_result_t               result_out,
  output logic                       result_valid_out
);

  // ---------------------------------------------
  // declarations
  // ---------------------------------------------
  logic                    rst_meta_r;
  logic                    rst_n;
  logic                    sclk_prev_r;
  logic                    sclk_rise;
  logic                    sclk_fall;
  sadc_state_t             state_r;
  sadc_state_t             state_nxt;
  logic [`SADC_CNT_W-1:0]  nbits;
  logic [`SADC_CNT_W-1:0]  bit_cnt_r;
  logic [`SADC_CNT_W-1:0]  bit_idx_r;
  logic [`SADC_ADDR_W-1:0] addr_r;
  logic [`SADC_ADDR_W-1:0] addr_shift;
  logic [`SADC_ADDR_W-1:0] addr_padded;
  sadc_mux_sel_t           sel_dec;
  logic                    replay_n;
  logic                    decision;
  logic [`SADC_RES_W-1:0]  bit_mask;
  logic [`SADC_RES_W-1:0]  result_r;
  logic [`SADC_RES_W-1:0]  result_nxt;
  logic                    fifo_push_r;
  sadc_result_t            fifo_word_r;
  logic                    fifo_in_ready;
  logic                    start_seen;
  logic                    last_bit;

  // ---------------------------------------------
  // reset release
  // ---------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // ---------------------------------------------
  // serial clock edges
  // ---------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev_r <= 1'b0;
    end else begin
      sclk_prev_r <= sclk_in;
    end
  end

  assign sclk_rise = sclk_in & ~sclk_prev_r;
  assign sclk_fall = ~sclk_in & sclk_prev_r;

  // ---------------------------------------------
  // variant dependent settings
  // ---------------------------------------------
  always_comb begin
    case (mux_variant_in)
      SADC_VAR_1CH: begin
        nbits    = `SADC_NBITS_1CH;
        replay_n = 1'b1;
      end
      SADC_VAR_2CH: begin
        nbits    = `SADC_NBITS_2CH;
        replay_n = 1'b0;
      end
      SADC_VAR_4CH: begin
        nbits    = `SADC_NBITS_4CH;
        replay_n = 1'b0;
      end
      default: begin
        nbits    = `SADC_NBITS_8CH;
        replay_n = lsb_replay_enable_n_in;
      end
    endcase
  end

  assign addr_shift = {addr_r[`SADC_ADDR_W-2:0], serial_data_in};

  always_comb begin
    case (mux_variant_in)
      SADC_VAR_4CH: addr_padded = {addr_shift[2:0], `SADC_FORCED_SEL0};
      SADC_VAR_2CH: addr_padded = {addr_shift[1:0], `SADC_FORCED_SEL1, `SADC_FORCED_SEL0};
      default:      addr_padded = addr_shift;
    endcase
  end

  sadc_mux_decode u_decode (
    .variant_in (mux_variant_in),
    .addr_in    (addr_padded),
    .sel_out    (sel_dec)
  );

  // ---------------------------------------------
  // conversion sequence
  // ---------------------------------------------
  assign start_seen = sclk_rise & serial_data_in & fifo_in_ready;
  assign last_bit   = (bit_idx_r == `SADC_LSB_IDX);

  always_comb begin
    state_nxt = state_r;
    if (cs_n_in) begin
      state_nxt = SADC_ST_IDLE;
    end else begin
      case (state_r)
        SADC_ST_IDLE: begin
          state_nxt = SADC_ST_WAIT;
        end
        SADC_ST_WAIT: begin
          if (start_seen) begin
            if (nbits == `SADC_NBITS_1CH) begin
              state_nxt = SADC_ST_SAMPLE;
            end else begin
              state_nxt = SADC_ST_ADDR;
            end
          end
        end
        SADC_ST_ADDR: begin
          if (sclk_rise && bit_cnt_r == `SADC_CNT_LAST) begin
            state_nxt = SADC_ST_SAMPLE;
          end
        end
        SADC_ST_SAMPLE: begin
          if (sclk_fall) state_nxt = SADC_ST_CONVERT;
        end
        SADC_ST_CONVERT: begin
          if (sclk_fall && last_bit) state_nxt = SADC_ST_SETTLE;
        end
        SADC_ST_SETTLE: begin
          if (sclk_rise) state_nxt = SADC_ST_REPLAY;
        end
        SADC_ST_REPLAY: begin
          if (sclk_fall && !replay_n && bit_idx_r == `SADC_MSB_IDX) begin
            state_nxt = SADC_ST_DONE;
          end
        end
        SADC_ST_DONE: begin
          state_nxt = SADC_ST_DONE;
        end
        default: begin
          state_nxt = SADC_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SADC_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------
  // selection word capture
  // ---------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      addr_r    <= `SADC_ADDR_RST;
      bit_cnt_r <= '0;
    end else if (cs_n_in) begin
      addr_r    <= `SADC_ADDR_RST;
      bit_cnt_r <= '0;
    end else if (state_r == SADC_ST_WAIT && start_seen) begin
      bit_cnt_r <= nbits;
    end else if (state_r == SADC_ST_ADDR && sclk_rise) begin
      addr_r    <= addr_shift;
      bit_cnt_r <= bit_cnt_r - `SADC_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      mux_select_out <= '0;
    end else if (cs_n_in) begin
      mux_select_out <= '0;
    end else if (state_r != SADC_ST_SAMPLE && state_nxt == SADC_ST_SAMPLE) begin
      mux_select_out <= sel_dec;
    end
  end

  // ---------------------------------------------
  // successive approximation
  // ---------------------------------------------
  assign decision   = comparator_in & ~input_reversed_in;
  assign bit_mask   = `SADC_RES_W'(1) << bit_idx_r;
  assign result_nxt = decision ? (result_r | bit_mask) : (result_r & ~bit_mask);

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      dac_code_out <= `SADC_TRIAL_INIT;
      result_r     <= `SADC_RESULT_RST;
      bit_idx_r    <= `SADC_MSB_IDX;
    end else if (cs_n_in) begin
      dac_code_out <= `SADC_TRIAL_INIT;
      result_r     <= `SADC_RESULT_RST;
      bit_idx_r    <= `SADC_MSB_IDX;
    end else if (sclk_fall) begin
      case (state_r)
        SADC_ST_SAMPLE: begin
          dac_code_out <= `SADC_TRIAL_INIT;
          result_r     <= `SADC_RESULT_RST;
          bit_idx_r    <= `SADC_MSB_IDX;
        end
        SADC_ST_CONVERT: begin
          result_r     <= result_nxt;
          dac_code_out <= result_nxt | (bit_mask >> 1);
          if (!last_bit) bit_idx_r <= bit_idx_r - `SADC_CNT_W'(1);
        end
        SADC_ST_REPLAY: begin
          if (!replay_n && bit_idx_r != `SADC_MSB_IDX) begin
            bit_idx_r <= bit_idx_r + `SADC_CNT_W'(1);
          end
        end
        default: begin
          bit_idx_r <= bit_idx_r;
        end
      endcase
    end
  end

  // ---------------------------------------------
  // sample and status outputs
  // ---------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      sample_out <= 1'b0;
    end else begin
      sample_out <= (state_nxt == SADC_ST_SAMPLE);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      conversion_active_out      <= 1'b0;
      conversion_active_oe_n_out <= 1'b1;
    end else if (cs_n_in) begin
      conversion_active_out      <= 1'b0;
      conversion_active_oe_n_out <= 1'b1;
    end else begin
      conversion_active_oe_n_out <= 1'b0;
      if (state_r == SADC_ST_SAMPLE && sclk_fall) begin
        conversion_active_out <= 1'b1;
      end else if (state_r == SADC_ST_SETTLE && sclk_rise) begin
        conversion_active_out <= 1'b0;
      end
    end
  end

  // ---------------------------------------------
  // serial data out
  // ---------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      serial_data_out      <= 1'b0;
      serial_data_oe_n_out <= 1'b1;
    end else if (cs_n_in) begin
      serial_data_out      <= 1'b0;
      serial_data_oe_n_out <= 1'b1;
    end else if (sclk_fall) begin
      case (state_r)
        SADC_ST_SAMPLE: begin
          serial_data_out      <= 1'b0;
          serial_data_oe_n_out <= 1'b0;
        end
        SADC_ST_CONVERT: begin
          serial_data_out <= decision;
        end
        SADC_ST_REPLAY: begin
          if (!replay_n) begin
            serial_data_out      <= result_r[bit_idx_r];
            serial_data_oe_n_out <= 1'b0;
          end else begin
            serial_data_oe_n_out <= 1'b1;
          end
        end
        SADC_ST_DONE: begin
          serial_data_oe_n_out <= 1'b1;
        end
        default: begin
          serial_data_out <= serial_data_out;
        end
      endcase
    end
  end

  // ---------------------------------------------
  // result buffer
  // ---------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      fifo_push_r <= 1'b0;
      fifo_word_r <= '0;
    end else begin
      fifo_push_r <= 1'b0;
      if (state_r == SADC_ST_CONVERT && sclk_fall && last_bit && !cs_n_in) begin
        fifo_push_r        <= 1'b1;
        fifo_word_r.sel    <= mux_select_out;
        fifo_word_r.result <= result_nxt;
      end
    end
  end

  sadc_fifo #(
    .WIDTH ($bits(sadc_result_t)),
    .DEPTH (`SADC_FIFO_DEPTH),
    .CNT_W (`SADC_FIFO_CNT_W)
  ) u_fifo (
    .clk_in        (clk_sys_in),
    .rst_n_in      (rst_n),
    .in_data_in    (fifo_word_r),
    .in_valid_in   (fifo_push_r),
    .in_ready_out  (fifo_in_ready),
    .out_data_out  (result_out),
    .out_valid_out (result_valid_out),
    .out_ready_in  (result_ready_in)
  );

endmodule : sadc_top

// >>> verification/sadc_top_assertions.sv
// concurrent checks on the converter control pins
// assumes binding into sadc_top, one clock domain
`timescale 1ns/10ps
module sadc_top_checker import sadc_pkg::*; (
  input wire logic         clk_sys_in,
  input wire logic         reset_n_in,
  input wire logic         cs_n_in,
  input wire logic         sclk_in,
  input wire logic         input_reversed_in,
  input wire logic         result_ready_in,
  input wire logic         serial_data_out,
  input wire logic         serial_data_oe_n_out,
  input wire logic         conversion_active_out,
  input wire logic         conversion_active_oe_n_out,
  input wire logic         sample_out,
  input wire logic [7:0]   dac_code_out,
  input wire sadc_result_t result_out,
  input wire logic         result_valid_out
);
  // ----
  // properties
  // ----
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  AST_CS_FLOATS: assert property (cs_n_in [*3] |-> serial_data_oe_n_out && conversion_active_oe_n_out)
    else $error("pin driven while deselected");
  AST_CS_CLEARS: assert property (cs_n_in [*3] |-> dac_code_out == 8'h80 && !sample_out)
    else $error("state not cleared while deselected");
  AST_LEAD_ZERO: assert property ($rose(conversion_active_out) |-> $fell(serial_data_oe_n_out) && !serial_data_out)
    else $error("no leading zero at conversion start");
  AST_SAMPLE_FIRST: assert property ($rose(conversion_active_out) |-> $past(sample_out) && !sample_out)
    else $error("status rose without sample window");
  AST_STATUS_END: assert property (!cs_n_in && $fell(conversion_active_out) |-> sclk_in && !serial_data_oe_n_out)
    else $error("status fell off the clock rise");
  AST_DATA_AT_FALL: assert property (!serial_data_oe_n_out && !$past(serial_data_oe_n_out)
    && $changed(serial_data_out) |-> !sclk_in)
    else $error("data changed while clock high");
  AST_ACTIVE_DRIVES: assert property (conversion_active_out |-> !serial_data_oe_n_out)
    else $error("status high with output floating");
  AST_REVERSED_ZERO: assert property (input_reversed_in [*8] ##1 (input_reversed_in && conversion_active_out)
    |-> !serial_data_out)
    else $error("one bit with reversed inputs");
  AST_HEAD_HOLDS: assert property (result_valid_out && !result_ready_in |=> result_valid_out && $stable(result_out))
    else $error("buffer head moved without ready");
  cover property ($fell(conversion_active_out));
  cover property (result_valid_out && !result_ready_in);
  cover property ($rose(cs_n_in) && !serial_data_oe_n_out);
endmodule : sadc_top_checker

bind sadc_top sadc_top_checker chk_u (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .cs_n_in(cs_n_in),
  .sclk_in(sclk_in), .input_reversed_in(input_reversed_in), .result_ready_in(result_ready_in),
  .serial_data_out(serial_data_out), .serial_data_oe_n_out(serial_data_oe_n_out),
  .conversion_active_out(conversion_active_out), .conversion_active_oe_n_out(conversion_active_oe_n_out),
  .sample_out(sample_out), .dac_code_out(dac_code_out), .result_out(result_out),
  .result_valid_out(result_valid_out));

// >>> verification/sadc_host_model.sv
// host controller model driving the serial pins
// assumes a system clock to pace its serial clock
`timescale 1ns/10ps
module sadc_host_model #(
  parameter int HALF = 4
) (
  input  wire logic clk_in,
  input  wire logic sdo_in,
  input  wire logic sdo_oe_n_in,
  output logic      cs_n_out,
  output logic      sclk_out,
  output logic      sdi_out,
  output logic      replay_n_out
);
  logic       rel_r;
  logic       smp;
  logic       oe_s;
  logic       lead_r;
  logic       drove_r;
  logic       float_r;
  logic [7:0] msb_r;
  logic [7:0] lsb_r;
  // ----
  // serial frames
  // ----
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
    replay_n_out = 1'b1;
    rel_r = 1'b0;
  end
  // released data line shows a changing pattern
  always @(posedge clk_in) if (rel_r) sdi_out <= ~sdi_out;
  task automatic period(input logic b);
    sclk_out <= 1'b0;
    if (!rel_r) sdi_out <= b;
    repeat (HALF) @(posedge clk_in);
    smp = sdo_in ^ sdo_oe_n_in;
    oe_s = sdo_oe_n_in;
    drove_r = drove_r | ~sdo_oe_n_in;
    sclk_out <= 1'b1;
    repeat (HALF) @(posedge clk_in);
  endtask : period
  task automatic convert(input logic [3:0] w, input int nb, input int lead, input int mode, input int cut);
    drove_r = 1'b0;
    float_r = 1'b1;
    msb_r = 8'h00;
    lsb_r = 8'h00;
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    replay_n_out <= !(mode == 1 || mode == 4);
    repeat (2) @(posedge clk_in);
    repeat (lead) period(1'b0);
    period(1'b1);
    for (int i = 0; i < nb; i++) period(w[3-i]);
    rel_r <= 1'b1;
    period(1'b0);
    lead_r = smp | oe_s;
    if (cut > 0) begin
      repeat (cut) period(1'b0);
    end else begin
      for (int i = 7; i >= 0; i--) begin
        period(1'b0);
        msb_r[i] = smp;
      end
      if (mode == 2) begin
        repeat (2) begin
          period(1'b0);
          float_r = float_r & oe_s;
        end
        replay_n_out <= 1'b0;
        @(posedge clk_in);
      end
      if (mode >= 1 && mode <= 3) begin
        for (int i = 0; i < 8; i++) begin
          period(1'b0);
          lsb_r[i] = smp;
        end
      end
      period(1'b0);
      float_r = float_r & oe_s;
    end
    cs_n_out <= 1'b1;
    rel_r <= 1'b0;
    replay_n_out <= 1'b1;
    repeat (3) @(posedge clk_in);
  endtask : convert
endmodule : sadc_host_model

// >>> verification/tb_sadc_top.sv
// self-checking bench of the converter control block
// assumes design files and host model compiled first
`timescale 1ns/10ps
module tb_sadc_top import sadc_pkg::*; ;
  logic          clk_sys_in;
  logic          reset_n_in;
  logic          cs_n;
  logic          sclk;
  logic          sdi;
  logic          rep_n;
  sadc_variant_t var_r;
  logic [7:0]    vin_r;
  logic          rev_r;
  logic          rdy_r;
  logic          cmp;
  logic          sdo;
  logic          sdo_oe_n;
  logic          act;
  logic          act_oe_n;
  logic [7:0]    dac;
  sadc_result_t  res;
  logic          res_v;
  int            fails;
  int            tests_run;
  sadc_result_t  exp_q[$];
  sadc_result_t  msk_q[$];
  // ----
  // harness
  // ----
  always #10 clk_sys_in = ~clk_sys_in;
  assign cmp = {vin_r, 1'b1} > {dac, 1'b0};
  sadc_host_model host_u (.clk_in(clk_sys_in), .sdo_in(sdo), .sdo_oe_n_in(sdo_oe_n), .cs_n_out(cs_n),
    .sclk_out(sclk), .sdi_out(sdi), .replay_n_out(rep_n));
  sadc_top dut_u (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .cs_n_in(cs_n), .sclk_in(sclk),
    .serial_data_in(sdi), .lsb_replay_enable_n_in(rep_n), .mux_variant_in(var_r), .comparator_in(cmp),
    .input_reversed_in(rev_r), .result_ready_in(rdy_r), .serial_data_out(sdo), .serial_data_oe_n_out(sdo_oe_n),
    .conversion_active_out(act), .conversion_active_oe_n_out(act_oe_n), .sample_out(), .dac_code_out(dac),
    .mux_select_out(), .result_out(res), .result_valid_out(res_v));
  task automatic check_bits(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_bits
  task automatic check_entry(input sadc_result_t got, input sadc_result_t exp, input sadc_result_t m);
    tests_run++;
    if (((got ^ exp) & m) !== 17'h0) begin
      fails++;
      $display("CHECK FAILED at %0t: entry got %h exp %h", $time, got, exp);
    end
  endtask : check_entry
  function automatic int nbits(input sadc_variant_t v);
    nbits = (v == SADC_VAR_8CH) ? 4 : (v == SADC_VAR_4CH) ? 3 : (v == SADC_VAR_2CH) ? 2 : 0;
  endfunction : nbits
  task automatic conv(input sadc_variant_t v, input logic [3:0] w, input logic [7:0] a, input logic rv,
                      input int mode, input bit full);
    logic [7:0]   r;
    sadc_result_t e;
    sadc_result_t m;
    r = rv ? 8'h00 : a;
    @(posedge clk_sys_in);
    var_r <= v;
    vin_r <= a;
    rev_r <= rv;
    host_u.convert(w, nbits(v), $urandom_range(0, 3), mode, 0);
    if (full) begin
      check_bits({7'h0, host_u.drove_r}, 8'h00, "start taken while full");
    end else begin
      check_bits({7'h0, host_u.lead_r}, 8'h00, "leading zero");
      check_bits(host_u.msb_r, r, "msb stream");
      check_bits(host_u.lsb_r, (mode >= 1 && mode <= 3) ? r : 8'h00, "lsb replay");
      check_bits({7'h0, host_u.float_r}, 8'h01, "float after");
      e = '0;
      e.result = r;
      case (v)
        SADC_VAR_8CH: e.sel.pos_ch = {w[1], w[0], w[2]};
        SADC_VAR_4CH: e.sel.pos_ch = {1'b0, w[1], w[2]};
        SADC_VAR_2CH: e.sel.pos_ch = {2'b00, w[2]};
        default: e.sel.pos_ch = 3'h0;
      endcase
      e.sel.single_ended = (v != SADC_VAR_1CH) && w[3];
      e.sel.neg_common = e.sel.single_ended;
      e.sel.neg_ch = e.sel.pos_ch ^ 3'h1;
      e.sel.common_grounded = (v == SADC_VAR_2CH || v == SADC_VAR_4CH);
      m = '1;
      if (e.sel.single_ended) m.sel.neg_ch = 3'h0;
      if (v == SADC_VAR_1CH) m.sel.common_grounded = 1'b0;
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
  endtask : conv
  task automatic drain();
    int t;
    while (exp_q.size() > 0) begin
      t = 0;
      while (res_v !== 1'b1 && t < 100) begin
        @(posedge clk_sys_in);
        t++;
      end
      check_entry(res, exp_q.pop_front(), msk_q.pop_front());
      repeat ($urandom_range(0, 3)) @(posedge clk_sys_in);
      rdy_r <= 1'b1;
      @(posedge clk_sys_in);
      rdy_r <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
    end
  endtask : drain
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  initial begin
    #1000000;
    fails++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    conclude();
  end
  // ----
  // tests
  // ----
  initial begin
    clk_sys_in = 1'b0;
    reset_n_in = 1'b0;
    var_r = SADC_VAR_8CH;
    vin_r = 8'h00;
    rev_r = 1'b0;
    rdy_r = 1'b0;
    fails = 0;
    tests_run = 0;
    void'($urandom(32'h9bcf));
    repeat (5) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    for (int v = 0; v < 4; v++) begin
      for (int w = 0; w < 16; w++) begin
        if ((w % (1 << (4 - nbits(sadc_variant_t'(v[1:0]))))) != 0) continue;
        conv(sadc_variant_t'(v[1:0]), 4'(w), (w == 0) ? 8'hff : 8'($urandom), w == 4,
             (v == 3) ? w % 3 : (v == 0) ? 4 : 3, 1'b0);
        drain();
      end
    end
    $display("test decode done");
    for (int i = 0; i < 8; i++) conv(SADC_VAR_8CH, 4'($urandom), 8'($urandom), 1'b0, 0, 1'b0);
    check_bits({7'h0, res_v}, 8'h01, "buffer holds");
    conv(SADC_VAR_8CH, 4'h8, 8'h55, 1'b0, 0, 1'b1);
    drain();
    check_bits({7'h0, res_v}, 8'h00, "buffer empty");
    $display("test buffer done");
    host_u.convert(4'hb, 4, 0, 0, 3);
    check_bits({6'h0, sdo_oe_n, act_oe_n}, 8'h03, "abort floats");
    check_bits({7'h0, res_v}, 8'h00, "abort leaves no result");
    conv(SADC_VAR_4CH, 4'ha, 8'h3c, 1'b0, 3, 1'b0);
    drain();
    $display("test abort done");
    conclude();
  end
endmodule : tb_sadc_top
